// ### design/rrce_exec.sv
`timescale 1ns/100ps
`default_nettype none
module rrce_exec (
  input  wire logic                         clk,
  input  wire logic                         resetn,
  input  wire logic [rrce_pkg::PA_W-1:0]    paddr,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [31:0]                  pwdata,
  output logic [31:0]                       prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         instr_valid,
  input  wire logic [15:0]                  instr,
  output logic                              instr_taken,
  output logic                              instr_discard,
  input  wire logic [rrce_pkg::PC_W-1:0]    stack_top,
  output logic                              stack_pop,
  input  wire rrce_pkg::rrce_shadow_t       shadow,
  input  wire logic [rrce_pkg::DA_W-1:0]    index_base,
  output rrce_pkg::rrce_dm_req_t            dm_req,
  input  wire logic [7:0]                   dm_rdata,
  output logic [rrce_pkg::PC_W-1:0]         pc,
  output logic [7:0]                        acc,
  output logic [rrce_pkg::FLAGS_W-1:0]      flags,
  output logic [rrce_pkg::BANK_W-1:0]       bank
);
  logic [1:0]           rst_pipe;
  logic                 rst_n;
  logic [1:0]           phase;
  logic                 q1;
  logic                 q4;
  rrce_pkg::rrce_core_t s_reg;
  rrce_pkg::rrce_core_t s_next;
  logic                 is_ret;
  logic                 is_rot;
  logic [7:0]           fld;
  logic [rrce_pkg::DA_W-1:0] addr_sel;
  logic                 sw_wr;
  logic                 sw_rd;
  logic [31:0]          rd_word;
  logic                 rd_hit;
  logic [7:0]           rot_res;
  logic                 rot_c;
  logic                 rot_z;
  logic                 rot_n;

  // Reset release through two flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  rrce_qphase u_qphase (
    .clk   (clk),
    .rst_n (rst_n),
    .phase (phase),
    .q1    (q1),
    .q4    (q4)
  );

  rrce_rotate u_rotate (
    .operand   (s_reg.operand),
    .carry_in  (s_reg.flags[rrce_pkg::FLAG_C]),
    .result    (rot_res),
    .carry_out (rot_c),
    .zero      (rot_z),
    .negative  (rot_n)
  );

  // Opcode decode
  assign is_ret = ((instr & rrce_pkg::OP_RET_MASK) == rrce_pkg::OP_RET_BASE);
  assign is_rot = ((instr & rrce_pkg::OP_ROT_MASK) == rrce_pkg::OP_ROT_BASE);
  assign fld    = instr[7:0];

  // Operand address resolution
  always_comb begin
    if (instr[rrce_pkg::ROT_A_BIT]) begin
      addr_sel = {s_reg.bank, fld}; // [RULE_08]
    end else if (s_reg.ext_en && (fld <= rrce_pkg::ACCESS_LAST_LOW)) begin
      addr_sel = rrce_pkg::DA_W'(index_base + {4'h0, fld}); // [RULE_09]
    end else if (fld <= rrce_pkg::ACCESS_LAST_LOW) begin
      addr_sel = {rrce_pkg::ACCESS_LOW_BANK, fld}; // [RULE_07]
    end else begin
      addr_sel = {rrce_pkg::ACCESS_HI_BANK, fld}; // [RULE_07]
    end
  end

  // Bus strobes
  assign sw_rd = psel && !penable;
  assign sw_wr = psel && penable && pwrite;

  // Read mux
  always_comb begin
    rd_word = rrce_pkg::ZERO_WORD;
    rd_hit  = 1'b1;
    case (paddr)
      rrce_pkg::REG_CTRL:  rd_word[rrce_pkg::CTRL_EXT_BIT] = s_reg.ext_en;
      rrce_pkg::REG_ACC:   rd_word[7:0] = s_reg.acc;
      rrce_pkg::REG_FLAGS: rd_word[rrce_pkg::FLAGS_W-1:0] = s_reg.flags;
      rrce_pkg::REG_BANK:  rd_word[rrce_pkg::BANK_W-1:0] = s_reg.bank;
      rrce_pkg::REG_PC:    rd_word[rrce_pkg::PC_W-1:0] = s_reg.pc;
      rrce_pkg::REG_STATE: rd_word[1:0] = s_reg.st;
      default:             rd_hit = 1'b0;
    endcase
  end

  // Next state: bus side first, execution overrides it
  always_comb begin
    s_next = s_reg;
    if (sw_rd) begin
      s_next.prdata  = rd_word;
      s_next.pslverr = !rd_hit;
    end
    if (sw_wr) begin
      case (paddr)
        rrce_pkg::REG_CTRL:  s_next.ext_en = pwdata[rrce_pkg::CTRL_EXT_BIT];
        rrce_pkg::REG_ACC:   s_next.acc = pwdata[7:0];
        rrce_pkg::REG_FLAGS: s_next.flags = pwdata[rrce_pkg::FLAGS_W-1:0];
        rrce_pkg::REG_BANK:  s_next.bank = pwdata[rrce_pkg::BANK_W-1:0];
        default: ;
      endcase
    end
    case (s_reg.st)
      rrce_pkg::EX_IDLE: begin
        if (q1 && instr_valid && is_ret) begin
          s_next.st  = rrce_pkg::EX_RET;
          s_next.ins = instr;
        end else if (q1 && instr_valid && is_rot) begin
          s_next.st      = rrce_pkg::EX_ROT;
          s_next.ins     = instr;
          s_next.dm_addr = addr_sel;
        end
      end
      rrce_pkg::EX_RET: begin
        if (q4) begin
          s_next.pc = stack_top; // [RULE_01] [RULE_03]
          if (s_reg.ins[rrce_pkg::RET_S_BIT]) begin
            s_next.acc   = shadow.acc;   // [RULE_02]
            s_next.flags = shadow.flags; // [RULE_02]
            s_next.bank  = shadow.bank;  // [RULE_02]
          end
          s_next.st = rrce_pkg::EX_FLUSH; // [RULE_04]
        end
      end
      rrce_pkg::EX_ROT: begin
        if (phase == rrce_pkg::QPH_Q2) begin
          s_next.operand = dm_rdata;
        end
        if (phase == rrce_pkg::QPH_Q3) begin
          s_next.result = rot_res;
          s_next.carry  = rot_c;
          s_next.flags[rrce_pkg::FLAG_Z] = rot_z; // [RULE_10]
          s_next.flags[rrce_pkg::FLAG_N] = rot_n; // [RULE_10]
        end
        if (q4) begin
          s_next.flags[rrce_pkg::FLAG_C] = s_reg.carry; // [RULE_05]
          s_next.flags[rrce_pkg::FLAG_Z] = s_reg.flags[rrce_pkg::FLAG_Z];
          s_next.flags[rrce_pkg::FLAG_N] = s_reg.flags[rrce_pkg::FLAG_N];
          if (!s_reg.ins[rrce_pkg::ROT_D_BIT]) begin
            s_next.acc = s_reg.result; // [RULE_06]
          end
          s_next.st = rrce_pkg::EX_IDLE; // [RULE_10]
        end
      end
      rrce_pkg::EX_FLUSH: begin
        if (q4) begin
          s_next.st = rrce_pkg::EX_IDLE; // [RULE_04]
        end
      end
      default: s_next.st = rrce_pkg::EX_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg         <= '0;
      s_reg.st      <= rrce_pkg::EX_IDLE;
      s_reg.pc      <= rrce_pkg::PC_RST;
      s_reg.acc     <= rrce_pkg::ACC_RST;
      s_reg.flags   <= rrce_pkg::FLAGS_RST;
      s_reg.bank    <= rrce_pkg::BANK_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs
  assign prdata        = s_reg.prdata;
  assign pready        = 1'b1;
  assign pslverr       = s_reg.pslverr;
  assign pc            = s_reg.pc;
  assign acc           = s_reg.acc;
  assign flags         = s_reg.flags;
  assign bank          = s_reg.bank;
  assign instr_taken   = (s_reg.st == rrce_pkg::EX_IDLE) && q1 && instr_valid
                         && (is_ret || is_rot);
  assign instr_discard = (s_reg.st == rrce_pkg::EX_FLUSH); // [RULE_04]
  assign stack_pop     = (s_reg.st == rrce_pkg::EX_RET) && q4; // [RULE_01]
  // Data memory request
  assign dm_req.addr   = s_reg.dm_addr;
  assign dm_req.wdata  = s_reg.result;
  assign dm_req.re     = (s_reg.st == rrce_pkg::EX_ROT);
  assign dm_req.we     = (s_reg.st == rrce_pkg::EX_ROT) && q4
                         && s_reg.ins[rrce_pkg::ROT_D_BIT]; // [RULE_06]

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Return commits in the last phase of its first cycle
  sequence ret_commit;
    (s_reg.st == rrce_pkg::EX_RET) && q4;
  endsequence

  // Rotate commits in the last phase of its only cycle
  sequence rot_commit;
    (s_reg.st == rrce_pkg::EX_ROT) && q4;
  endsequence

  // Rotate accepted, any addressing mode
  sequence rot_any_take;
    (s_reg.st == rrce_pkg::EX_IDLE) && q1 && instr_valid && is_rot;
  endsequence

  // Rotate accepted with a given bank bit and index window hit
  sequence rot_take(bit a, bit idx);
    (s_reg.st == rrce_pkg::EX_IDLE) && q1 && instr_valid && is_rot
    && (instr[rrce_pkg::ROT_A_BIT] == a)
    && ((s_reg.ext_en && (fld <= rrce_pkg::ACCESS_LAST_LOW)) == idx);
  endsequence

  // Return: pop, restore, keep, length
  chk_ret_pc_load: assert property (ret_commit |-> // [RULE_01]
    stack_pop ##1 pc == $past(stack_top))
    else $error("return did not load pc from stack top");
  chk_ret_pop_once: assert property (ret_commit |=> // [RULE_01]
    (!stack_pop)[*7])
    else $error("stack popped more than once");
  chk_ret_shadow_copy: assert property ( // [RULE_02]
    ret_commit ##0 s_reg.ins[rrce_pkg::RET_S_BIT] |=>
    acc == $past(shadow.acc) && flags == $past(shadow.flags) && bank == $past(shadow.bank))
    else $error("shadow restore missing");
  chk_ret_keep_live: assert property ( // [RULE_03]
    ret_commit ##0 (!s_reg.ins[rrce_pkg::RET_S_BIT] && !sw_wr) |=>
    $stable(acc) && $stable(flags) && $stable(bank))
    else $error("return without restore changed live state");
  chk_ret_two_cycles: assert property (ret_commit |=> // [RULE_04]
    instr_discard[*4] ##1 (s_reg.st == rrce_pkg::EX_IDLE))
    else $error("return did not take two cycles");
  chk_flush_no_take: assert property ((s_reg.st == rrce_pkg::EX_FLUSH) |-> // [RULE_04]
    instr_discard && !instr_taken)
    else $error("flush cycle accepted an instruction");
  chk_ret_no_mem: assert property ( // [RULE_04]
    (s_reg.st == rrce_pkg::EX_RET) || (s_reg.st == rrce_pkg::EX_FLUSH) |->
    !dm_req.re && !dm_req.we)
    else $error("return touched data memory");

  // Rotate: data path, destination, flags
  chk_rot_carry_in: assert property (rot_commit |=> // [RULE_05]
    flags[rrce_pkg::FLAG_C] == $past(s_reg.operand[7])
    && (!$past(s_reg.ins[rrce_pkg::ROT_D_BIT]) -> acc[0] == $past(s_reg.result[0])))
    else $error("rotate carry wrong");
  chk_rot_operand_read: assert property (rot_commit |-> // [RULE_05]
    s_reg.operand == $past(dm_rdata, 2))
    else $error("rotate operand not taken from memory");
  chk_rot_dest_sel: assert property (rot_commit |-> // [RULE_06]
    dm_req.we == s_reg.ins[rrce_pkg::ROT_D_BIT]
    && dm_req.wdata == {s_reg.operand[6:0], $past(flags[rrce_pkg::FLAG_C])})
    else $error("rotate destination wrong");
  chk_rot_acc_keep: assert property ( // [RULE_06]
    rot_commit ##0 (s_reg.ins[rrce_pkg::ROT_D_BIT] && !sw_wr) |=> $stable(acc))
    else $error("rotate to memory changed the accumulator");
  chk_rot_we_at_end: assert property (rot_any_take |=> // [RULE_06]
    (!dm_req.we)[*2] ##1 (dm_req.we == $past(instr[rrce_pkg::ROT_D_BIT], 3)))
    else $error("rotate write strobe misplaced");
  chk_rot_re_level: assert property (rot_any_take |=> // [RULE_10]
    dm_req.re[*3] ##1 !dm_req.re)
    else $error("rotate read strobe length wrong");
  chk_rot_flags_len: assert property (rot_take(1'b0, 1'b0) |=> // [RULE_10]
    (s_reg.st == rrce_pkg::EX_ROT)[*3] ##1 (s_reg.st == rrce_pkg::EX_IDLE)
    && flags[rrce_pkg::FLAG_Z] == ($past(s_reg.result) == 8'h00)
    && flags[rrce_pkg::FLAG_N] == $past(s_reg.result[7]))
    else $error("rotate flags or length wrong");

  // Operand address
  chk_access_addr: assert property (rot_take(1'b0, 1'b0) |=> // [RULE_07]
    dm_req.addr == {(($past(fld) <= rrce_pkg::ACCESS_LAST_LOW) ? rrce_pkg::ACCESS_LOW_BANK
                                                               : rrce_pkg::ACCESS_HI_BANK),
                    $past(fld)})
    else $error("access bank address wrong");
  chk_banked_addr: assert property (rot_any_take ##0 instr[rrce_pkg::ROT_A_BIT] |=> // [RULE_08]
    dm_req.addr == {$past(bank), $past(fld)})
    else $error("banked address wrong");
  chk_indexed_addr: assert property (rot_take(1'b0, 1'b1) |=> // [RULE_09]
    dm_req.addr == rrce_pkg::DA_W'($past(index_base) + {4'h0, $past(fld)}))
    else $error("indexed address wrong");

  // No pop, discard or memory strobe while idle
  chk_idle_quiet: assert property ((s_reg.st == rrce_pkg::EX_IDLE) |-> // [RULE_04]
    !stack_pop && !instr_discard && !dm_req.re && !dm_req.we)
    else $error("strobe active while idle");
endmodule
`default_nettype wire

// ### design/rrce_pkg.sv
// Operation
// [RULE_01] A subroutine return pops the call stack and loads the popped return address into the program counter.
// [RULE_02] A return with its low opcode bit set copies the shadow accumulator, flags and bank pointer into the live ones; with it clear they stay as they are.
// [RULE_03] A return never touches the upper and high program counter latches and changes no flag except through the shadow restore.
// [RULE_04] A return takes two instruction cycles: the pop happens in the last phase of the first, and the second is a no-operation that discards the prefetched instruction.
// [RULE_05] Rotate-left-through-carry shifts the operand left by one, moves its old top bit into carry and its old carry into bit zero.
// [RULE_06] A rotate with destination bit 0 writes the accumulator, and with destination bit 1 writes back the addressed data register.
// [RULE_07] A rotate with bank-access bit 0 resolves its 8-bit address inside the fixed access bank.
// [RULE_08] A rotate with bank-access bit 1 forms its address from the bank pointer and the 8-bit field.
// [RULE_09] With the extended set enabled, bank-access bit 0 and a field of at most 95, the field is an offset from the index base.
// [RULE_10] A rotate sets the sign flag from result bit 7 and the zero flag on a zero result, and completes in one instruction cycle.
`default_nettype none
package rrce_pkg;

  // Widths
  localparam int PC_W    = 21;
  localparam int DA_W    = 12;
  localparam int FLAGS_W = 5;
  localparam int BANK_W  = 4;
  localparam int PA_W    = 12;

  // Opcode matching
  localparam logic [15:0] OP_RET_BASE = 16'h0012;
  localparam logic [15:0] OP_RET_MASK = 16'hfffe;
  localparam logic [15:0] OP_ROT_BASE = 16'h3400;
  localparam logic [15:0] OP_ROT_MASK = 16'hfc00;
  localparam int          RET_S_BIT   = 0;
  localparam int          ROT_D_BIT   = 9;
  localparam int          ROT_A_BIT   = 8;

  // Access bank split and indexed window
  localparam logic [7:0]        ACCESS_LAST_LOW = 8'h5f;
  localparam logic [BANK_W-1:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_HI_BANK  = 4'hf;

  // Flag positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 4;

  // Phase codes of the four-phase instruction cycle
  localparam logic [1:0] QPH_Q1 = 2'h0;
  localparam logic [1:0] QPH_Q2 = 2'h1;
  localparam logic [1:0] QPH_Q3 = 2'h2;
  localparam logic [1:0] QPH_Q4 = 2'h3;

  // Register byte offsets
  localparam logic [PA_W-1:0] REG_CTRL  = 12'h000;
  localparam logic [PA_W-1:0] REG_ACC   = 12'h004;
  localparam logic [PA_W-1:0] REG_FLAGS = 12'h008;
  localparam logic [PA_W-1:0] REG_BANK  = 12'h00c;
  localparam logic [PA_W-1:0] REG_PC    = 12'h010;
  localparam logic [PA_W-1:0] REG_STATE = 12'h014;
  localparam int              CTRL_EXT_BIT = 0;

  // Reset values and the all-zero read-mux default word
  localparam logic [7:0]         ACC_RST   = 8'h00;
  localparam logic [FLAGS_W-1:0] FLAGS_RST = 5'h00;
  localparam logic [BANK_W-1:0]  BANK_RST  = 4'h0;
  localparam logic [PC_W-1:0]    PC_RST    = 21'h00_0000;
  localparam logic [31:0]        ZERO_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {EX_IDLE, EX_RET, EX_ROT, EX_FLUSH} rrce_exec_st_t;

  typedef struct packed {
    logic [7:0]         acc;
    logic [FLAGS_W-1:0] flags;
    logic [BANK_W-1:0]  bank;
  } rrce_shadow_t;

  typedef struct packed {
    logic [DA_W-1:0] addr;
    logic [7:0]      wdata;
    logic            re;
    logic            we;
  } rrce_dm_req_t;

  typedef struct packed {
    rrce_exec_st_t      st;
    logic [15:0]        ins;
    logic [PC_W-1:0]    pc;
    logic [7:0]         acc;
    logic [FLAGS_W-1:0] flags;
    logic [BANK_W-1:0]  bank;
    logic               ext_en;
    logic [DA_W-1:0]    dm_addr;
    logic [7:0]         operand;
    logic [7:0]         result;
    logic               carry;
    logic [31:0]        prdata;
    logic               pslverr;
  } rrce_core_t;

  typedef struct packed {
    logic [1:0] cnt;
  } rrce_qph_t;

endpackage
`default_nettype wire

// ### design/rrce_qphase.sv
`timescale 1ns/100ps
`default_nettype none
module rrce_qphase (
  input  wire logic       clk,
  input  wire logic       rst_n,
  output logic [1:0]      phase,
  output logic            q1,
  output logic            q4
);
  rrce_pkg::rrce_qph_t s_reg;
  rrce_pkg::rrce_qph_t s_next;

  // Phase counter, wraps every four clocks
  always_comb begin
    s_next     = s_reg;
    s_next.cnt = s_reg.cnt + 2'h1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Phase enables
  assign phase = s_reg.cnt;
  assign q1    = (s_reg.cnt == rrce_pkg::QPH_Q1);
  assign q4    = (s_reg.cnt == rrce_pkg::QPH_Q4);

  chk_phase_wraps: assert property (@(posedge clk) disable iff (!rst_n)
    q4 |=> q1)
    else $error("phase did not wrap from last to first");
endmodule
`default_nettype wire

// ### design/rrce_rotate.sv
`timescale 1ns/100ps
`default_nettype none
module rrce_rotate (
  input  wire logic [7:0] operand,
  input  wire logic       carry_in,
  output logic [7:0]      result,
  output logic            carry_out,
  output logic            zero,
  output logic            negative
);
  // Left rotate through carry and its flags
  always_comb begin
    result    = {operand[6:0], carry_in}; // [RULE_05]
    carry_out = operand[7];               // [RULE_05]
    zero      = (result == 8'h00);        // [RULE_10]
    negative  = result[7];                // [RULE_10]
  end
endmodule
`default_nettype wire

// ### verification/rrce_exec_bench.sv
`timescale 1ns/100ps
`default_nettype none
module rrce_exec_bench;
  logic                    clk;
  logic                    resetn;
  logic [11:0]             paddr;
  logic                    psel;
  logic                    penable;
  logic                    pwrite;
  logic [31:0]             pwdata;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  logic                    instr_valid;
  logic [15:0]             instr;
  logic                    instr_taken;
  logic                    instr_discard;
  logic [20:0]             stack_top;
  logic                    stack_pop;
  rrce_pkg::rrce_shadow_t  shadow;
  logic [11:0]             index_base;
  rrce_pkg::rrce_dm_req_t  dm_req;
  logic [7:0]              dm_rdata;
  logic [20:0]             pc;
  logic [7:0]              acc;
  logic [4:0]              flags;
  logic [3:0]              bank;
  int                      n_errors;
  int                      n_checks;
  logic [7:0]              m_acc;
  logic [4:0]              m_flags;
  logic [3:0]              m_bank;

  rrce_exec dut_u (
    .clk           (clk),
    .resetn        (resetn),
    .paddr         (paddr),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .pwdata        (pwdata),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .instr_valid   (instr_valid),
    .instr         (instr),
    .instr_taken   (instr_taken),
    .instr_discard (instr_discard),
    .stack_top     (stack_top),
    .stack_pop     (stack_pop),
    .shadow        (shadow),
    .index_base    (index_base),
    .dm_req        (dm_req),
    .dm_rdata      (dm_rdata),
    .pc            (pc),
    .acc           (acc),
    .flags         (flags),
    .bank          (bank)
  );

  // Clock, 50 ns period
  always #25 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // One APB transfer, held until pready is seen
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int k;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] ad, input logic [31:0] wd);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, ad, wd, rd, err);
  endtask

  task automatic rdchk(input logic [11:0] ad, input logic [31:0] exp, input logic experr);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, ad, 32'h0000_0000, rd, err);
    check(rd, exp);
    check({31'h0, err}, {31'h0, experr});
  endtask

  // Presents an opcode until taken; returns at mid-cycle after the taking edge
  task automatic issue(input logic [15:0] op);
    int k;
    @(posedge clk);
    instr_valid <= 1'b1;
    instr       <= op;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (instr_taken !== 1'b1 && k < 16);
    check({31'h0, instr_taken}, 32'h0000_0001);
    @(posedge clk);
    instr_valid <= 1'b0;
    @(negedge clk);
  endtask

  // Rotate with expected result worked out from the bench model
  task automatic rot(input logic d, input logic a, input logic [7:0] f,
                     input logic [7:0] op, input logic [11:0] exp_addr);
    logic [7:0] r;
    logic [4:0] fl;
    r = {op[6:0], m_flags[0]};
    fl = m_flags;
    fl[0] = op[7];
    fl[2] = (r == 8'h00);
    fl[4] = r[7];
    @(posedge clk);
    dm_rdata <= op;
    issue({6'b0011_01, d, a, f});
    check({20'h0, dm_req.addr}, {20'h0, exp_addr});
    check({31'h0, dm_req.re}, 32'h0000_0001);
    repeat (2) @(negedge clk);
    check({31'h0, dm_req.we}, {31'h0, d});
    if (d) check({24'h0, dm_req.wdata}, {24'h0, r});
    @(negedge clk);
    if (!d) m_acc = r;
    m_flags = fl;
    check({24'h0, acc}, {24'h0, m_acc});
    check({27'h0, flags}, {27'h0, m_flags});
  endtask

  // Return, with optional shadow restore
  task automatic ret(input logic s, input logic [20:0] top);
    @(posedge clk);
    stack_top <= top;
    issue({15'h0009, s});
    @(negedge clk);
    check({31'h0, stack_pop}, 32'h0000_0000);
    @(negedge clk);
    check({31'h0, stack_pop}, 32'h0000_0001);
    @(negedge clk);
    if (s) begin
      m_acc = shadow.acc;
      m_flags = shadow.flags;
      m_bank = shadow.bank;
    end
    check({11'h0, pc}, {11'h0, top});
    check({15'h0, acc, flags, bank}, {15'h0, m_acc, m_flags, m_bank});
    check({31'h0, instr_discard}, 32'h0000_0001);
    repeat (3) @(negedge clk);
    check({31'h0, instr_discard}, 32'h0000_0001);
    @(negedge clk);
    check({31'h0, instr_discard}, 32'h0000_0000);
  endtask

  // Watchdog
  initial begin
    #(5000 * 50);
    n_errors++;
    give_verdict();
  end

  // Main sequence
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    {paddr, psel, penable, pwrite, pwdata} = '0;
    instr_valid = 1'b0;
    instr = 16'h0000;
    stack_top = 21'h0_0000;
    shadow = {8'ha5, 5'h15, 4'h9};
    index_base = 12'hff8;
    dm_rdata = 8'h00;
    n_errors = 0;
    n_checks = 0;
    m_acc = 8'h00;
    m_flags = 5'h00;
    m_bank = 4'h0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (5) @(posedge clk);
    rdchk(rrce_pkg::REG_CTRL, 32'h0000_0000, 1'b0);
    rdchk(rrce_pkg::REG_ACC, 32'h0000_0000, 1'b0);
    rdchk(rrce_pkg::REG_FLAGS, 32'h0000_0000, 1'b0);
    rdchk(rrce_pkg::REG_PC, 32'h0000_0000, 1'b0);
    rdchk(rrce_pkg::REG_BANK, 32'h0000_0000, 1'b0);
    rdchk(rrce_pkg::REG_STATE, 32'h0000_0000, 1'b0);
    rdchk(12'h100, 32'h0000_0000, 1'b1);
    $display("test registers done");
    wr(rrce_pkg::REG_BANK, 32'h0000_0003);
    m_bank = 4'h3;
    rot(1'b0, 1'b0, 8'h5f, 8'h80, 12'h05f);
    rot(1'b1, 1'b0, 8'h60, 8'h41, 12'hf60);
    rot(1'b0, 1'b1, 8'h12, 8'hc3, 12'h312);
    wr(rrce_pkg::REG_CTRL, 32'h0000_0001);
    rot(1'b1, 1'b0, 8'h10, 8'h01, 12'h008);
    $display("test rotate done");
    wr(rrce_pkg::REG_ACC, 32'h0000_005a);
    wr(rrce_pkg::REG_FLAGS, 32'h0000_000a);
    wr(rrce_pkg::REG_BANK, 32'h0000_0006);
    m_acc = 8'h5a;
    m_flags = 5'h0a;
    m_bank = 4'h6;
    ret(1'b0, 21'h1_abcd);
    ret(1'b1, 21'h0_0246);
    rdchk(rrce_pkg::REG_ACC, 32'h0000_00a5, 1'b0);
    rdchk(rrce_pkg::REG_FLAGS, 32'h0000_0015, 1'b0);
    rdchk(rrce_pkg::REG_BANK, 32'h0000_0009, 1'b0);
    wr(rrce_pkg::REG_PC, 32'h0000_1234);
    rdchk(rrce_pkg::REG_PC, 32'h0000_0246, 1'b0);
    rdchk(rrce_pkg::REG_STATE, 32'h0000_0000, 1'b0);
    $display("test return done");
    give_verdict();
  end
endmodule
`default_nettype wire
